// [core/ucpm_pkg.sv]
// ucpm_pkg: constants, register map and types for the charge port mode controller.
// assumes a 25 MHz core clock and a 32-bit Avalon-MM register slave.
package ucpm_pkg;

  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned DEBOUNCE_US = 10;
  localparam int unsigned DEBOUNCE_CYC = (DEBOUNCE_US * (CLK_HZ / 1_000_000) < 1) ? 1 :
                                         DEBOUNCE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned DB_W = 9;

  // ==========================================================
  // register byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_IRQ_STAT = 4'h8;
  localparam logic [3:0] OFS_IRQ_MASK = 4'hC;

  // control fields
  localparam int unsigned CTRL_NTC_VARIANT_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  // status fields
  localparam int unsigned ST_STATE_LSB = 0;
  localparam int unsigned ST_ADV_LSB = 4;
  localparam int unsigned ST_USBM_LSB = 6;
  localparam int unsigned ST_WARN_BIT = 8;
  localparam int unsigned ST_DIE_HOT_BIT = 9;
  localparam int unsigned ST_NTC_SD_BIT = 10;
  localparam int unsigned ST_RESV_BIT = 11;

  // interrupt event bits
  localparam int unsigned EV_W = 4;
  localparam int unsigned EV_ATTACH = 0;
  localparam int unsigned EV_DETACH = 1;
  localparam int unsigned EV_WARN = 2;
  localparam int unsigned EV_TSD = 3;
  localparam logic [EV_W-1:0] IRQ_MASK_RESET = 4'h0;

  // ==========================================================
  // types
  typedef enum logic [1:0] {ADV_DEFAULT, ADV_1A5, ADV_3A0} ucpm_adv_e;
  typedef enum logic [1:0] {USBM_NONE, USBM_SDP, USBM_CDP, USBM_DCP_AUTO} ucpm_usbm_e;
  typedef enum logic [2:0] {ST_SHUTDOWN, ST_STANDBY, ST_ACTIVE, ST_DIE_TSD, ST_NTC_TSD} ucpm_state_e;

endpackage : ucpm_pkg

// [core/ucpm_top.sv]
// ucpm_top: mode and protection controller of a Type-C charge port with buck regulator.
// assumes comparator and pin levels arrive as digital inputs in the core clock domain.
//
// Implementation choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ns

// Behaviour
// (R01) die overtemperature: gate drive low and buck switching stopped.
// (R02) restart after die shutdown only once the cooled-by-hysteresis comparator reports.
// (R03) port bus stays at 0 V, buck off, until a sink is detected on CC.
// (R04) thermistor warning at 3 A advertisement lowers advertisement to 1.5 A.
// (R05) thermistor warning raises thermal warning flag, fault stays low.
// (R06) thermistor shutdown level turns buck off and gate drive low.
// (R07) during thermistor shutdown warning flag stays high, fault stays low.
// (R08) enable below threshold keeps device in shutdown, regulator off.
// (R09) input or internal supply undervoltage holds regulator off.
// (R10) enabled without sink: low-power standby, buck off, until sink pull-down appears.
// (R11) active only with enable, both supplies good and valid sink detection.
// (R12) active mode uses forced fixed-frequency switching at all loads.
// (R13) switching locks to a valid external clock on the sync input.
// (R14) mode pins 10: 1.5 A SDP; 11: 3 A CDP; 01 thermistor variant: 3 A DCP auto.
// (R15) controller never drives 00, nor 01 on the variant without thermistor.
// (R16) mode pins are monitored continuously and the mode follows them.
// (R17) all comparator and pin inputs are synchronised and debounced before use.
module ucpm_top
  import ucpm_pkg::*;
#(
  parameter int unsigned DEB_CYC = DEBOUNCE_CYC
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // comparators and pins
  input wire logic i_enable_above_th,
  input wire logic i_vin_uvlo_ok,
  input wire logic i_vcc_uvlo_ok,
  input wire logic i_cc1_sink_rd,
  input wire logic i_cc2_sink_rd,
  input wire logic i_die_over_limit,
  input wire logic i_die_cooled,
  input wire logic i_ntc_warn,
  input wire logic i_ntc_shutdown,
  input wire logic i_mode_select_hi,
  input wire logic i_mode_select_lo,
  input wire logic i_ext_sync_valid,
  // avalon-mm slave
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // power path control
  output logic o_buck_enable,
  output logic o_forced_fixed_freq_switching,
  output logic o_sync_lock_enable,
  output logic o_ext_switch_gate_drive,
  // port advertisement and flags
  output logic [1:0] o_cc_advertisement,
  output logic [1:0] o_usb_mode,
  output logic o_thermal_warning_flag,
  output logic o_fault,
  output logic o_irq
);

  localparam int unsigned NIN = 12;

  typedef struct packed {
    logic [NIN-1:0] sync1;
    logic [NIN-1:0] sync2;
    logic [NIN-1:0] clean;
    logic [NIN-1:0][DB_W-1:0] cnt;
    ucpm_state_e state;
    ucpm_adv_e adv;
    ucpm_usbm_e usbm;
    logic resv;
    logic ntc_variant;
    logic [EV_W-1:0] irq_stat;
    logic [EV_W-1:0] irq_mask;
    logic [31:0] rdata;
    logic wait_n;
    logic buck;
    logic ffs;
    logic sync_en;
    logic gate;
    logic warn;
    logic irq;
  } ucpm_state_s;

  ucpm_state_s r;
  ucpm_state_s next_r;

  logic [NIN-1:0] raw_in;
  assign raw_in = {i_ext_sync_valid, i_mode_select_lo, i_mode_select_hi, i_ntc_shutdown,
                   i_ntc_warn, i_die_cooled, i_die_over_limit, i_cc2_sink_rd,
                   i_cc1_sink_rd, i_vcc_uvlo_ok, i_vin_uvlo_ok, i_enable_above_th};

  // debounced input aliases
  logic d_en, d_vin, d_vcc, d_cc1, d_cc2, d_dhot, d_dcool, d_nwarn, d_nsd, d_m_hi, d_m_lo, d_sync;
  assign {d_sync, d_m_lo, d_m_hi, d_nsd, d_nwarn, d_dcool, d_dhot,
          d_cc2, d_cc1, d_vcc, d_vin, d_en} = r.clean;

  // ==========================================================
  // helpers
  function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge_be

  logic power_ok;
  logic sink_seen;
  logic [31:0] status_word;
  logic [EV_W-1:0] events;
  logic [31:0] wmerged;
  logic access;

  always_comb begin
    next_r = r;
    power_ok = d_en && d_vin && d_vcc;
    sink_seen = d_cc1 || d_cc2;
    events = '0;
    wmerged = '0;
    access = i_avs_read || i_avs_write;

    // two-flop synchroniser then a stable-count debounce
    next_r.sync1 = raw_in;
    next_r.sync2 = r.sync1;
    for (int k = 0; k < NIN; k++) begin
      if (r.sync2[k] == r.clean[k]) begin
        next_r.cnt[k] = '0;
      end else if (r.cnt[k] >= DB_W'(DEB_CYC - 1)) begin
        next_r.cnt[k] = '0;
        next_r.clean[k] = r.sync2[k]; // R17
      end else begin
        next_r.cnt[k] = r.cnt[k] + DB_W'(1);
      end
    end

    // mode decode is live in every state; reserved codes fall back to default advertisement
    next_r.resv = 1'b0;
    unique case ({d_m_hi, d_m_lo})
      2'b10: begin
        next_r.adv = ADV_1A5; // R14 R16
        next_r.usbm = USBM_SDP;
      end
      2'b11: begin
        next_r.adv = ADV_3A0; // R14 R16
        next_r.usbm = USBM_CDP;
      end
      2'b01: begin
        if (r.ntc_variant) begin
          next_r.adv = ADV_3A0; // R14
          next_r.usbm = USBM_DCP_AUTO;
        end else begin
          next_r.adv = ADV_DEFAULT; // R15
          next_r.usbm = USBM_NONE;
          next_r.resv = 1'b1;
        end
      end
      2'b00: begin
        next_r.adv = ADV_DEFAULT; // R15
        next_r.usbm = USBM_NONE;
        next_r.resv = 1'b1;
      end
    endcase
    // thermistor warning trims a 3 A advertisement only on the thermistor variant
    if (r.ntc_variant && (d_nwarn || d_nsd) && next_r.adv == ADV_3A0) begin
      next_r.adv = ADV_1A5; // R04
    end
    next_r.warn = r.ntc_variant && (d_nwarn || d_nsd); // R05 R07

    // power state machine; die shutdown takes priority over everything once powered
    unique case (r.state)
      ST_SHUTDOWN: begin
        if (power_ok) begin
          next_r.state = ST_STANDBY; // R08 R09
        end
      end
      ST_STANDBY: begin
        if (!power_ok) begin
          next_r.state = ST_SHUTDOWN;
        end else if (d_dhot) begin
          next_r.state = ST_DIE_TSD;
        end else if (r.ntc_variant && d_nsd) begin
          next_r.state = ST_NTC_TSD;
        end else if (sink_seen && !r.resv) begin
          next_r.state = ST_ACTIVE; // R10 R11
          events[EV_ATTACH] = 1'b1;
        end
      end
      ST_ACTIVE: begin
        if (!power_ok) begin
          next_r.state = ST_SHUTDOWN; // R08 R09
          events[EV_DETACH] = 1'b1;
        end else if (d_dhot) begin
          next_r.state = ST_DIE_TSD; // R01
          events[EV_TSD] = 1'b1;
        end else if (r.ntc_variant && d_nsd) begin
          next_r.state = ST_NTC_TSD; // R06
          events[EV_TSD] = 1'b1;
        end else if (!sink_seen || r.resv) begin
          next_r.state = ST_STANDBY; // R03
          events[EV_DETACH] = 1'b1;
        end
      end
      ST_DIE_TSD: begin
        // restart waits for the hysteresis comparator, not just the limit dropping
        if (!d_dhot && d_dcool) begin
          next_r.state = power_ok ? ST_STANDBY : ST_SHUTDOWN; // R02
        end
      end
      ST_NTC_TSD: begin
        if (!power_ok) begin
          next_r.state = ST_SHUTDOWN;
        end else if (d_dhot) begin
          next_r.state = ST_DIE_TSD;
        end else if (!d_nsd) begin
          next_r.state = ST_STANDBY;
        end
      end
      // three of the eight state codes are unused; recover through shutdown
      default: begin
        next_r.state = ST_SHUTDOWN;
      end
    endcase

    // bus is cold everywhere but active mode
    next_r.buck = (next_r.state == ST_ACTIVE); // R03 R10 R11
    next_r.gate = (next_r.state == ST_ACTIVE); // R01 R06
    next_r.ffs = (next_r.state == ST_ACTIVE); // R12
    next_r.sync_en = (next_r.state == ST_ACTIVE) && d_sync; // R13

    if (d_nwarn && !r.warn && r.ntc_variant) begin
      events[EV_WARN] = 1'b1;
    end

    // ======================================================
    // avalon slave: one wait cycle, answer on the second edge
    status_word = '0;
    status_word[ST_STATE_LSB +: 3] = r.state;
    status_word[ST_ADV_LSB +: 2] = r.adv;
    status_word[ST_USBM_LSB +: 2] = r.usbm;
    status_word[ST_WARN_BIT] = r.warn;
    status_word[ST_DIE_HOT_BIT] = d_dhot;
    status_word[ST_NTC_SD_BIT] = d_nsd;
    status_word[ST_RESV_BIT] = r.resv;

    next_r.wait_n = access && !r.wait_n;
    next_r.irq_stat = r.irq_stat;
    if (access && r.wait_n && i_avs_write) begin
      wmerged = merge_be(32'h0, i_avs_writedata, i_avs_byteenable);
      unique case (i_avs_address)
        OFS_CTRL: begin
          if (i_avs_byteenable[0]) begin
            next_r.ntc_variant = i_avs_writedata[CTRL_NTC_VARIANT_BIT];
          end
        end
        OFS_IRQ_STAT: next_r.irq_stat = r.irq_stat & ~wmerged[EV_W-1:0];
        OFS_IRQ_MASK: begin
          // a function result cannot be part-selected, so merge through the scratch word
          wmerged = merge_be({28'h0, r.irq_mask}, i_avs_writedata, i_avs_byteenable);
          next_r.irq_mask = wmerged[EV_W-1:0];
        end
        default: ;
      endcase
    end
    // a new event wins over a same-cycle clear
    next_r.irq_stat = next_r.irq_stat | events;
    next_r.irq = |(next_r.irq_stat & next_r.irq_mask);

    if (access && !r.wait_n && i_avs_read) begin
      unique case (i_avs_address)
        OFS_CTRL: next_r.rdata = {31'h0, r.ntc_variant};
        OFS_STATUS: next_r.rdata = status_word;
        OFS_IRQ_STAT: next_r.rdata = {28'h0, r.irq_stat};
        OFS_IRQ_MASK: next_r.rdata = {28'h0, r.irq_mask};
        default: next_r.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      r <= '0;
      r.state <= ST_SHUTDOWN;
      r.adv <= ADV_DEFAULT;
      r.usbm <= USBM_NONE;
      r.ntc_variant <= CTRL_RESET[CTRL_NTC_VARIANT_BIT];
      r.irq_mask <= IRQ_MASK_RESET;
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from state flops, except o_fault tied low
  assign o_avs_readdata = r.rdata;
  assign o_avs_waitrequest = !r.wait_n;
  assign o_buck_enable = r.buck;
  assign o_forced_fixed_freq_switching = r.ffs;
  assign o_sync_lock_enable = r.sync_en;
  assign o_ext_switch_gate_drive = r.gate;
  assign o_cc_advertisement = r.adv;
  assign o_usb_mode = r.usbm;
  assign o_thermal_warning_flag = r.warn;
  assign o_fault = 1'b0; // R05 R07
  assign o_irq = r.irq;

endmodule : ucpm_top

// [sim/ucpm_checker.sv]
// ucpm_checker: port assertions on ucpm_top, bound at the foot.
// assumes DEB_CYC of 4, so a debounced input acts within 8 cycles.
`timescale 1ns/1ns
module ucpm_checker
  import ucpm_pkg::*;
#(
  parameter int unsigned DEB_CYC = 4
) (
  // clock, reset, inputs
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_enable_above_th,
  input wire logic i_cc1_sink_rd,
  input wire logic i_cc2_sink_rd,
  input wire logic i_die_over_limit,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  // outputs
  input wire logic o_avs_waitrequest,
  input wire logic o_buck_enable,
  input wire logic o_forced_fixed_freq_switching,
  input wire logic o_sync_lock_enable,
  input wire logic o_ext_switch_gate_drive,
  input wire logic [1:0] o_cc_advertisement,
  input wire logic o_thermal_warning_flag,
  input wire logic o_fault
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  // ==========================================================
  // power path
  property p_die_off; i_die_over_limit [*8] |-> ##[0:8] !o_buck_enable && !o_ext_switch_gate_drive; endproperty
  a_die_off: assert property (p_die_off) else $error("buck on while die hot");
  property p_no_sink; (!i_cc1_sink_rd && !i_cc2_sink_rd) [*8] |-> ##[0:8] !o_buck_enable; endproperty
  a_no_sink: assert property (p_no_sink) else $error("buck on without sink");
  property p_en_off; !i_enable_above_th [*8] |-> ##[0:8] !o_buck_enable; endproperty
  a_en_off: assert property (p_en_off) else $error("buck on while disabled");
  property p_gate; $rose(o_ext_switch_gate_drive) |-> o_buck_enable; endproperty
  a_gate: assert property (p_gate) else $error("gate on with buck off");
  property p_fixed; o_buck_enable |-> o_forced_fixed_freq_switching; endproperty
  a_fixed: assert property (p_fixed) else $error("buck on without fixed freq");
  property p_sync; o_sync_lock_enable |-> o_forced_fixed_freq_switching; endproperty
  a_sync: assert property (p_sync) else $error("sync lock outside active");
  // ==========================================================
  // flags and bus
  property p_fault; !o_fault; endproperty
  a_fault: assert property (p_fault) else $error("fault raised");
  property p_warn_adv; o_thermal_warning_flag && o_buck_enable |-> o_cc_advertisement != ADV_3A0; endproperty
  a_warn_adv: assert property (p_warn_adv) else $error("3A kept under warning");
  property p_ack; $rose(i_avs_read || i_avs_write) |=> !o_avs_waitrequest ##1 o_avs_waitrequest; endproperty
  a_ack: assert property (p_ack) else $error("bus answer late");
endmodule : ucpm_checker

bind ucpm_top ucpm_checker #(.DEB_CYC(DEB_CYC)) u_chk (.i_mclk(i_mclk), .i_reset(i_reset),
  .i_enable_above_th(i_enable_above_th), .i_cc1_sink_rd(i_cc1_sink_rd), .i_cc2_sink_rd(i_cc2_sink_rd),
  .i_die_over_limit(i_die_over_limit), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_waitrequest(o_avs_waitrequest), .o_buck_enable(o_buck_enable),
  .o_forced_fixed_freq_switching(o_forced_fixed_freq_switching), .o_sync_lock_enable(o_sync_lock_enable),
  .o_ext_switch_gate_drive(o_ext_switch_gate_drive), .o_cc_advertisement(o_cc_advertisement),
  .o_thermal_warning_flag(o_thermal_warning_flag), .o_fault(o_fault));

// [sim/ucpm_sink_model.sv]
// ucpm_sink_model: sink at the port, shows Rd on one CC line.
// assumes attach, flip and slow change just after a clock edge.
`timescale 1ns/1ns
module ucpm_sink_model (
  // control
  input wire logic i_mclk,
  input wire logic i_attach,
  input wire logic i_flip,
  input wire logic i_slow,
  // cc lines
  output logic o_cc1_rd = 1'b0,
  output logic o_cc2_rd = 1'b0
);
  logic [3:0] cnt = 4'h0;
  // a slow plug takes cycles to settle its pull-down
  always @(posedge i_mclk) begin
    if (!i_attach) begin
      cnt <= 4'h0;
      o_cc1_rd <= 1'b0;
      o_cc2_rd <= 1'b0;
    end else if (i_slow && cnt != 4'h9) begin
      cnt <= cnt + 4'h1;
    end else begin
      o_cc1_rd <= !i_flip;
      o_cc2_rd <= i_flip;
    end
  end
endmodule : ucpm_sink_model

// [sim/testbench.sv]
// testbench: scenario tasks for ucpm_top with a sink model.
// assumes DEB_CYC of 4; waits derive from it.
`timescale 1ns/1ns
module testbench;
  import ucpm_pkg::*;
  localparam int DEB = 4;
  localparam int SETTLE = DEB + 12;
  logic clk = 1'b0, rst = 1'b1, en = 1'b0, vin = 1'b0, vcc = 1'b0, die = 1'b0, cool = 1'b0;
  logic nw = 1'b0, nsd = 1'b0, mhi = 1'b1, mlo = 1'b1, syn = 1'b0, rd = 1'b0, wr = 1'b0;
  logic att = 1'b0, flip = 1'b0, slow = 1'b0, cc1, cc2, wrq, buck, ffs, lock, gate, warn, fault, irq;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic [1:0] adv, usbm;
  int n_errors = 0, samples_checked = 0;
  always #20 clk = !clk;
  ucpm_sink_model u_sink (.i_mclk(clk), .i_attach(att), .i_flip(flip), .i_slow(slow),
    .o_cc1_rd(cc1), .o_cc2_rd(cc2));
  ucpm_top #(.DEB_CYC(DEB)) DUT (.i_mclk(clk), .i_reset(rst), .i_enable_above_th(en),
    .i_vin_uvlo_ok(vin), .i_vcc_uvlo_ok(vcc), .i_cc1_sink_rd(cc1), .i_cc2_sink_rd(cc2),
    .i_die_over_limit(die), .i_die_cooled(cool), .i_ntc_warn(nw), .i_ntc_shutdown(nsd),
    .i_mode_select_hi(mhi), .i_mode_select_lo(mlo), .i_ext_sync_valid(syn), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wrq), .o_buck_enable(buck),
    .o_forced_fixed_freq_switching(ffs), .o_sync_lock_enable(lock), .o_ext_switch_gate_drive(gate),
    .o_cc_advertisement(adv), .o_usb_mode(usbm), .o_thermal_warning_flag(warn), .o_fault(fault),
    .o_irq(irq));
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    addr <= a;
    wdat <= d;
    rd <= !w;
    wr <= w;
    @(posedge clk);
    while (wrq !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n == 50) n_errors++;
    @(posedge clk);
  endtask : bus
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  task automatic pw(input logic [4:0] e);
    chk({27'h0, buck, gate, ffs, warn, fault}, {27'h0, e});
  endtask : pw
  task automatic st(input logic [2:0] e);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk({29'h0, q[2:0]}, {29'h0, e});
  endtask : st
  // ==========================================================
  // scenarios
  task automatic t_regs;
    bus(1'b0, OFS_CTRL, 32'h0);
    chk(q, CTRL_RESET);
    bus(1'b0, OFS_IRQ_MASK, 32'h0);
    chk(q, {28'h0, IRQ_MASK_RESET});
    bus(1'b1, 4'h2, 32'hFFFF_FFFF);
    bus(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_attach;
    en <= 1'b1;
    vin <= 1'b1;
    vcc <= 1'b1;
    wt(SETTLE);
    pw(5'b00000);
    st(ST_STANDBY);
    att <= 1'b1;
    syn <= 1'b1;
    wt(SETTLE);
    pw(5'b11100);
    chk({31'h0, lock}, 32'h1);
    st(ST_ACTIVE);
    $display("t_attach done");
  endtask : t_attach
  task automatic t_modes;
    logic [1:0] code [3] = '{2'b10, 2'b01, 2'b11};
    logic [1:0] ea [3] = '{ADV_1A5, ADV_3A0, ADV_3A0};
    logic [1:0] eu [3] = '{USBM_SDP, USBM_DCP_AUTO, USBM_CDP};
    for (int i = 0; i < 3; i++) begin
      {mhi, mlo} <= code[i];
      wt(SETTLE);
      chk({28'h0, adv, usbm}, {28'h0, ea[i], eu[i]});
    end
    bus(1'b1, OFS_CTRL, 32'h0);
    {mhi, mlo} <= 2'b01;
    wt(SETTLE);
    chk({28'h0, adv, usbm}, {28'h0, ADV_DEFAULT, USBM_NONE});
    pw(5'b00000);
    bus(1'b1, OFS_CTRL, 32'h1);
    {mhi, mlo} <= 2'b11;
    wt(SETTLE);
    $display("t_modes done");
  endtask : t_modes
  task automatic t_die;
    logic ok;
    ok = 1'b1;
    die <= 1'b1;
    wt(SETTLE);
    pw(5'b00000);
    st(ST_DIE_TSD);
    die <= 1'b0;
    wt(SETTLE);
    pw(5'b00000);
    cool <= 1'b1;
    wt(SETTLE);
    pw(5'b11100);
    att <= 1'b0;
    wt(2);
    att <= 1'b1;
    for (int i = 0; i < SETTLE; i++) begin
      @(posedge clk);
      ok = ok & (buck === 1'b1);
    end
    chk({31'h0, ok}, 32'h1);
    {att, slow, flip} <= 3'b011;
    wt(SETTLE);
    pw(5'b00000);
    att <= 1'b1;
    wt(2 * SETTLE);
    pw(5'b11100);
    $display("t_die done");
  endtask : t_die
  task automatic t_supply;
    vin <= 1'b0;
    wt(SETTLE);
    pw(5'b00000);
    {vin, vcc} <= 2'b10;
    wt(SETTLE);
    pw(5'b00000);
    {vcc, en} <= 2'b10;
    wt(SETTLE);
    st(ST_SHUTDOWN);
    en <= 1'b1;
    wt(2 * SETTLE);
    pw(5'b11100);
    $display("t_supply done");
  endtask : t_supply
  task automatic t_ntc;
    chk({31'h0, irq}, 32'h0); // masked events keep the line low
    bus(1'b1, OFS_IRQ_STAT, 32'hF);
    bus(1'b1, OFS_IRQ_MASK, 32'hF);
    nw <= 1'b1;
    wt(SETTLE);
    pw(5'b11110);
    chk({28'h0, adv, usbm}, {28'h0, ADV_1A5, USBM_CDP});
    bus(1'b0, OFS_IRQ_STAT, 32'h0);
    chk({31'h0, q[EV_WARN]}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, OFS_IRQ_STAT, 32'hF);
    chk({31'h0, irq}, 32'h0);
    nsd <= 1'b1;
    wt(SETTLE);
    pw(5'b00010);
    st(ST_NTC_TSD);
    $display("t_ntc done");
  endtask : t_ntc
  // ==========================================================
  // run control
  task automatic test_done;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done
  initial begin
    #(40 * 6000);
    n_errors++;
    test_done;
  end
  initial begin
    wt(10);
    rst <= 1'b0;
    @(posedge clk);
    t_regs;
    t_attach;
    t_modes;
    t_die;
    t_supply;
    t_ntc;
    test_done;
  end
endmodule : testbench
